// ### bench/mocl_ctrl_model.sv
// closed-loop current controller model
// assumes the bench sets the demanded current
`timescale 1ns/1ps

module mocl_ctrl_model (
    // demand and limit
    input wire [31:0] demand_ma,
    input wire [31:0] current_limit_ma,
    // measured current
    output wire [31:0] motor_current_ma
);
    // follows demand, never above the applied limit
    assign motor_current_ma = (demand_ma < current_limit_ma) ? demand_ma : current_limit_ma;
endmodule // mocl_ctrl_model

// ### bench/mocl_limiter_checker.sv
// port-level assertions for the overload current limiter
// assumes the register map constants of mocl_defines.vh
`timescale 1ns/1ps
`include "mocl_defines.vh"

module mocl_limiter_checker #(
    parameter MS_CYCLES = 40
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    input wire ce,
    // register port
    input wire [15:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    // controller side
    input wire [31:0] current_limit_ma,
    input wire limiting,
    input wire irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_rdata_idle: assert property ($past(ce) && !$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read");
    a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) == 16'h0000
        |-> reg_rdata == 32'h0) else $error("unmapped read not zero");
    a_status_binary: assert property ($past(reg_rd) && $past(reg_addr) == `MOCL_ADDR_STATUS
        |-> reg_rdata[31:1] == 31'h0) else $error("status not 0 or 1");
    a_limit_readback: assert property ($past(reg_rd) && $past(reg_addr) == `MOCL_ADDR_LIMIT
        && $stable(current_limit_ma) |-> reg_rdata == current_limit_ma)
        else $error("limit readback differs from output");
    a_engage_drops: assert property ($rose(limiting)
        |-> current_limit_ma < $past(current_limit_ma)) else $error("limit not reduced");
    a_release_raises: assert property ($fell(limiting)
        |-> current_limit_ma > $past(current_limit_ma)) else $error("limit not raised");
    a_limit_steady: assert property (!$past(reg_wr) && !$past(reg_wr, 2) && $stable(limiting)
        |-> $stable(current_limit_ma)) else $error("limit moved without cause");
    a_irq_fields: assert property ($past(reg_rd) && $past(reg_addr) == `MOCL_ADDR_IRQ_STATUS
        |-> reg_rdata[31:3] == 29'h0) else $error("irq status upper bits set");

    c_engage: cover property ($rose(limiting));
    c_release: cover property ($fell(limiting));
    c_irq: cover property ($rose(irq));
endmodule // mocl_limiter_checker

bind mocl_limiter mocl_limiter_checker #(.MS_CYCLES(MS_CYCLES)) mocl_limiter_checker_inst (
    .clk(clk), .reset_n(reset_n), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .current_limit_ma(current_limit_ma),
    .limiting(limiting), .irq(irq));

// ### bench/motor_overload_current_limiter_tb.sv
// testbench for the overload current limiter
// assumes a 40 ms-tick-scaled parameter and no random stimulus
`timescale 1ns/1ps
`include "mocl_defines.vh"

module motor_overload_current_limiter_tb;
    localparam MS = 40;
    reg clk = 1'b0;
    reg reset_n = 1'b0;
    reg ce = 1'b1;
    reg [15:0] reg_addr = 16'h0;
    reg [31:0] reg_wdata = 32'h0;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [31:0] demand_ma = 32'h0;
    wire [31:0] reg_rdata;
    wire [31:0] motor_current_ma;
    wire [31:0] current_limit_ma;
    wire limiting;
    wire irq;
    int bad_count = 0;
    int n_compared = 0;
    logic [31:0] rv;
    int n;

    mocl_limiter #(.MS_CYCLES(MS)) mocl_limiter_inst (.clk(clk), .reset_n(reset_n), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .motor_current_ma(motor_current_ma),
        .current_limit_ma(current_limit_ma), .limiting(limiting), .irq(irq));
    mocl_ctrl_model mocl_ctrl_model_inst (.demand_ma(demand_ma),
        .current_limit_ma(current_limit_ma), .motor_current_ma(motor_current_ma));

    initial begin
        forever #12.5 clk = ~clk;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task complete_run;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task wait_lim(input logic lvl, input int bound, output int cnt);
        cnt = 0;
        while (limiting !== lvl && cnt < bound) begin
            @(posedge clk);
            #1 cnt++;
        end
        if (cnt >= bound) begin
            bad_count++;
            $display("Error at %0t: limiting wait ran out", $time);
            complete_run();
        end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_reset;
        rd(`MOCL_ADDR_RATED, rv); chk(rv, 32'h0);
        rd(`MOCL_ADDR_STATUS, rv); chk(rv, 32'h0);
        rd(16'h0000, rv); chk(rv, 32'h0);
        $display("test reset done");
    endtask

    task t_activate;
        wr(`MOCL_ADDR_CEILING, 32'd3000);
        wr(`MOCL_ADDR_RATED, 32'd1000);
        wr(`MOCL_ADDR_PEAK, 32'd1000);
        wr(`MOCL_ADDR_DURATION, 32'd4);
        wr(`MOCL_ADDR_IRQ_ENABLE, 32'h1);
        rd(`MOCL_ADDR_STATUS, rv); chk(rv, 32'h0);
        chk(current_limit_ma, 32'd3000);
        wr(`MOCL_ADDR_SUBMODE, 32'h1);
        rd(`MOCL_ADDR_STATUS, rv); chk(rv, 32'h0);
        wr(`MOCL_ADDR_PEAK, 32'd3000);
        rd(`MOCL_ADDR_STATUS, rv); chk(rv, 32'h1);
        rd(`MOCL_ADDR_THRESHOLD, rv); chk(rv, 32'd32);
        rd(`MOCL_ADDR_LIMIT, rv); chk(rv, 32'd3000);
        $display("test activate done");
    endtask

    task t_episode;
        chk({31'h0, irq}, 32'h0);
        demand_ma <= 32'd3000;
        wait_lim(1'b1, 10 * MS, n);
        chk({31'h0, n >= 3 * MS}, 32'h1);
        rd(`MOCL_ADDR_RUNNING, rv); chk(rv, 32'd32);
        rd(`MOCL_ADDR_LIMIT, rv); chk(rv, 32'd1000);
        chk({31'h0, irq}, 32'h1);
        wr(`MOCL_ADDR_IRQ_CLEAR, 32'h7);
        #1 chk({31'h0, irq}, 32'h0);
        $display("test episode done");
    endtask

    task t_retain;
        demand_ma <= 32'h0;
        wait_lim(1'b0, 3 * MS, n);
        rd(`MOCL_ADDR_RUNNING, rv); chk(rv, 32'd31);
        demand_ma <= 32'd3000;
        wait_lim(1'b1, 3 * MS, n);
        chk({31'h0, n <= MS + 2}, 32'h1);
        $display("test retain done");
    endtask

    task t_ceiling;
        demand_ma <= 32'h0;
        wait_lim(1'b0, 12 * MS, n);
        wr(`MOCL_ADDR_CEILING, 32'd1500);
        rd(`MOCL_ADDR_THRESHOLD, rv); chk(rv, 32'd4);
        chk({31'h0, current_limit_ma <= 32'd1500}, 32'h1);
        $display("test ceiling done");
    endtask

    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_activate();
        t_episode();
        t_retain();
        t_ceiling();
        complete_run();
    end
endmodule // motor_overload_current_limiter_tb

// ### design/mocl_defines.vh
// constants for the motor overload current limiter
// assumes a 40 MHz clock and a plain register port with 16-bit addresses
//
// What this block does
// [R1] The limiter works only while bit 0 of the drive submode register is 1.
// [R2] A writable absolute motor current ceiling in mA feeds the protection.
// [R3] A writable rated current in mA is the level used once the budget is spent.
// [R4] The peak current setting counts tenths of a percent of the rated current.
// [R5] A writable peak duration in ms bounds how long peak current may flow.
// [R6] The energy limit is derived from rated current, peak current and duration.
// [R7] The energy limit is readable in A2ms as the peak-or-rated threshold.
// [R8] A readable running value in A2ms is compared with the threshold.
// [R9] The current limit now imposed is readable in mA.
// [R10] Protection is active only if peak exceeds rated and duration is nonzero.
// [R11] Software must write all four settings consistently before activation.
// [R12] Peak current is allowed until the running value reaches the limit.
// [R13] The permitted peak current never exceeds the absolute ceiling.
// [R14] The running value is kept after a limiting episode.
// [R15] Each ms the running value rises or falls by the square excess, not below 0.
`ifndef MOCL_DEFINES_VH
`define MOCL_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define MOCL_ADDR_CEILING 16'h2031
`define MOCL_ADDR_PEAK 16'h6073
`define MOCL_ADDR_SUBMODE 16'h3202
`define MOCL_ADDR_RATED 16'h2041
`define MOCL_ADDR_DURATION 16'h2042
`define MOCL_ADDR_THRESHOLD 16'h2043
`define MOCL_ADDR_RUNNING 16'h2044
`define MOCL_ADDR_LIMIT 16'h2045
`define MOCL_ADDR_STATUS 16'h2046
`define MOCL_ADDR_IRQ_STATUS 16'h2050
`define MOCL_ADDR_IRQ_CLEAR 16'h2051
`define MOCL_ADDR_IRQ_ENABLE 16'h2052

// ----------------------------------------
// fields
// ----------------------------------------
`define MOCL_SUBMODE_CLOSED_BIT 0
`define MOCL_IRQ_ENGAGE_BIT 0
`define MOCL_IRQ_RELEASE_BIT 1
`define MOCL_IRQ_ACTIVE_BIT 2
`define MOCL_IRQ_WIDTH 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define MOCL_RST_CEILING 32'h00000000
`define MOCL_RST_PEAK 16'h0000
`define MOCL_RST_SUBMODE 8'h00
`define MOCL_RST_RATED 32'h00000000
`define MOCL_RST_DURATION 32'h00000000
`define MOCL_RST_IRQ_ENABLE 3'h0

// ----------------------------------------
// scaling and timing
// ----------------------------------------
`define MOCL_PERMILLE_DIV 48'h0000000003E8
`define MOCL_MA2_PER_A2 64'h00000000000F4240
`define MOCL_CLK_HZ 40000000
`define MOCL_TICK_US 1000
`define MOCL_MS_CYCLES ((`MOCL_CLK_HZ / 1000000) * `MOCL_TICK_US)

`endif

// ### design/mocl_limiter.v
// motor overload current limiter: register port, budget and limit output
// assumes inputs synchronous to clk and a current controller reading the limit
`timescale 1ns/1ps
`include "mocl_defines.vh"

module mocl_limiter #(
    parameter MS_CYCLES = `MOCL_MS_CYCLES
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    input wire ce,
    // register port
    input wire [15:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // current controller side
    input wire [31:0] motor_current_ma,
    output reg [31:0] current_limit_ma,
    output reg limiting,
    // interrupt
    output wire irq
);

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    reg [31:0] motor_current_ceiling;
    reg [15:0] peak_current_permille;
    reg [7:0] drive_submode;
    reg [31:0] rated_current_ma;
    reg [31:0] peak_duration_ms;
    reg [`MOCL_IRQ_WIDTH-1:0] irq_enable;
    reg [`MOCL_IRQ_WIDTH-1:0] irq_status;

    // ----------------------------------------
    // derived state
    // ----------------------------------------
    reg [31:0] overload_threshold;
    reg [31:0] overload_running_value;
    reg overload_active;
    reg [15:0] ms_count;

    wire wr_ceiling;
    wire wr_peak;
    wire wr_submode;
    wire wr_rated;
    wire wr_duration;
    wire wr_irq_clear;
    wire wr_irq_enable;

    assign wr_ceiling = reg_wr && (reg_addr == `MOCL_ADDR_CEILING);
    assign wr_peak = reg_wr && (reg_addr == `MOCL_ADDR_PEAK);
    assign wr_submode = reg_wr && (reg_addr == `MOCL_ADDR_SUBMODE);
    assign wr_rated = reg_wr && (reg_addr == `MOCL_ADDR_RATED);
    assign wr_duration = reg_wr && (reg_addr == `MOCL_ADDR_DURATION);
    assign wr_irq_clear = reg_wr && (reg_addr == `MOCL_ADDR_IRQ_CLEAR);
    assign wr_irq_enable = reg_wr && (reg_addr == `MOCL_ADDR_IRQ_ENABLE);

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            motor_current_ceiling <= `MOCL_RST_CEILING;
            peak_current_permille <= `MOCL_RST_PEAK;
            drive_submode <= `MOCL_RST_SUBMODE;
            rated_current_ma <= `MOCL_RST_RATED;
            peak_duration_ms <= `MOCL_RST_DURATION;
            irq_enable <= `MOCL_RST_IRQ_ENABLE;
        end else if (ce) begin
            if (wr_ceiling) begin
                motor_current_ceiling <= reg_wdata; // [R2]
            end
            if (wr_peak) begin
                peak_current_permille <= reg_wdata[15:0]; // [R4]
            end
            if (wr_submode) begin
                drive_submode <= reg_wdata[7:0];
            end
            if (wr_rated) begin
                rated_current_ma <= reg_wdata; // [R3]
            end
            if (wr_duration) begin
                peak_duration_ms <= reg_wdata; // [R5]
            end
            if (wr_irq_enable) begin
                irq_enable <= reg_wdata[`MOCL_IRQ_WIDTH-1:0];
            end
        end
    end

    // ----------------------------------------
    // peak current from permille of rated
    // ----------------------------------------
    wire [47:0] peak_prod;
    wire [47:0] peak_quot;
    wire [31:0] peak_current_ma;

    assign peak_prod = rated_current_ma * peak_current_permille; // [R4]
    assign peak_quot = peak_prod / `MOCL_PERMILLE_DIV;
    // clamp to the absolute ceiling
    assign peak_current_ma = (peak_quot > {16'h0000, motor_current_ceiling}) ?
        motor_current_ceiling : peak_quot[31:0]; // [R13]

    // ----------------------------------------
    // activation
    // ----------------------------------------
    wire closed_loop;
    wire next_active;

    assign closed_loop = drive_submode[`MOCL_SUBMODE_CLOSED_BIT]; // [R1]
    // needs peak above rated and a nonzero duration
    assign next_active = closed_loop && (peak_current_ma > rated_current_ma) &&
        (peak_duration_ms != 32'h00000000); // [R10] [R11]

    // ----------------------------------------
    // energy limit
    // ----------------------------------------
    wire [31:0] peak_excess_a2;
    wire [63:0] limit_prod;
    wire [31:0] next_threshold;

    mocl_sqdiff u_peak_sq (
        .a_ma(peak_current_ma),
        .b_ma(rated_current_ma),
        .mag_a2(peak_excess_a2),
        .a_ge_b()
    );

    // (peak^2 - rated^2) * duration, saturated
    assign limit_prod = peak_excess_a2 * peak_duration_ms; // [R6]
    assign next_threshold = (limit_prod[63:32] != 32'h00000000) ?
        32'hFFFFFFFF : limit_prod[31:0];

    // ----------------------------------------
    // millisecond tick
    // ----------------------------------------
    wire ms_tick;

    assign ms_tick = (ms_count == MS_CYCLES[15:0] - 16'h0001);

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ms_count <= 16'h0000;
        end else if (ce) begin
            if (ms_tick) begin
                ms_count <= 16'h0000;
            end else begin
                ms_count <= ms_count + 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // running value
    // ----------------------------------------
    wire [31:0] actual_excess_a2;
    wire above_rated;
    wire [32:0] run_sum;
    reg [31:0] next_running;

    mocl_sqdiff u_actual_sq (
        .a_ma(motor_current_ma),
        .b_ma(rated_current_ma),
        .mag_a2(actual_excess_a2),
        .a_ge_b(above_rated)
    );

    assign run_sum = {1'b0, overload_running_value} + {1'b0, actual_excess_a2};

    always @* begin
        next_running = overload_running_value; // [R14]
        if (overload_active && ms_tick) begin
            if (above_rated) begin
                // rise by the square excess, saturated
                next_running = run_sum[32] ? 32'hFFFFFFFF : run_sum[31:0]; // [R15]
            end else if (overload_running_value > actual_excess_a2) begin
                next_running = overload_running_value - actual_excess_a2; // [R15]
            end else begin
                next_running = 32'h00000000; // [R15]
            end
        end
    end

    // ----------------------------------------
    // limit selection
    // ----------------------------------------
    wire next_limiting;
    reg [31:0] next_limit;

    // budget spent once the running value reaches the threshold
    assign next_limiting = next_active && (next_running >= next_threshold); // [R8] [R12]

    always @* begin
        if (!next_active) begin
            next_limit = motor_current_ceiling;
        end else if (next_limiting) begin
            next_limit = rated_current_ma; // [R12]
        end else begin
            next_limit = peak_current_ma; // [R13]
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            overload_threshold <= 32'h00000000;
            overload_running_value <= 32'h00000000;
            overload_active <= 1'b0;
            current_limit_ma <= 32'h00000000;
            limiting <= 1'b0;
        end else if (ce) begin
            overload_threshold <= next_threshold; // [R7]
            overload_running_value <= next_running; // [R8]
            overload_active <= next_active; // [R10]
            current_limit_ma <= next_limit; // [R9]
            limiting <= next_limiting;
        end
    end

    // ----------------------------------------
    // interrupt status
    // ----------------------------------------
    wire [`MOCL_IRQ_WIDTH-1:0] irq_set;
    wire [`MOCL_IRQ_WIDTH-1:0] irq_clr;

    assign irq_set[`MOCL_IRQ_ENGAGE_BIT] = next_limiting && !limiting;
    assign irq_set[`MOCL_IRQ_RELEASE_BIT] = !next_limiting && limiting;
    assign irq_set[`MOCL_IRQ_ACTIVE_BIT] = next_active != overload_active;
    assign irq_clr = wr_irq_clear ? reg_wdata[`MOCL_IRQ_WIDTH-1:0] :
        {`MOCL_IRQ_WIDTH{1'b0}};

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_status <= {`MOCL_IRQ_WIDTH{1'b0}};
        end else if (ce) begin
            // a new event wins over a clear in the same cycle
            irq_status <= (irq_status & ~irq_clr) | irq_set;
        end
    end

    assign irq = |(irq_status & irq_enable);

    // ----------------------------------------
    // register reads
    // ----------------------------------------
    reg [31:0] next_rdata;

    always @* begin
        if (!reg_rd) begin
            next_rdata = 32'h00000000;
        end else if (reg_addr == `MOCL_ADDR_CEILING) begin
            next_rdata = motor_current_ceiling;
        end else if (reg_addr == `MOCL_ADDR_PEAK) begin
            next_rdata = {16'h0000, peak_current_permille};
        end else if (reg_addr == `MOCL_ADDR_SUBMODE) begin
            next_rdata = {24'h000000, drive_submode};
        end else if (reg_addr == `MOCL_ADDR_RATED) begin
            next_rdata = rated_current_ma;
        end else if (reg_addr == `MOCL_ADDR_DURATION) begin
            next_rdata = peak_duration_ms;
        end else if (reg_addr == `MOCL_ADDR_THRESHOLD) begin
            next_rdata = overload_threshold; // [R7]
        end else if (reg_addr == `MOCL_ADDR_RUNNING) begin
            next_rdata = overload_running_value; // [R8]
        end else if (reg_addr == `MOCL_ADDR_LIMIT) begin
            next_rdata = current_limit_ma; // [R9]
        end else if (reg_addr == `MOCL_ADDR_STATUS) begin
            next_rdata = {31'h00000000, overload_active}; // [R10]
        end else if (reg_addr == `MOCL_ADDR_IRQ_STATUS) begin
            next_rdata = {29'h00000000, irq_status};
        end else if (reg_addr == `MOCL_ADDR_IRQ_ENABLE) begin
            next_rdata = {29'h00000000, irq_enable};
        end else begin
            next_rdata = 32'h00000000;
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h00000000;
        end else if (ce) begin
            reg_rdata <= next_rdata;
        end
    end

endmodule // mocl_limiter

// ### design/mocl_sqdiff.v
// difference of two squared currents scaled from mA2 to A2
// assumes unsigned mA operands; purely combinational
`timescale 1ns/1ps
`include "mocl_defines.vh"

module mocl_sqdiff (
    // operands in mA
    input wire [31:0] a_ma,
    input wire [31:0] b_ma,
    // magnitude in A2, saturated, and sign
    output wire [31:0] mag_a2,
    output wire a_ge_b
);

    wire [63:0] sq_a;
    wire [63:0] sq_b;
    wire [63:0] diff;
    wire [63:0] quot;

    assign sq_a = a_ma * a_ma;
    assign sq_b = b_ma * b_ma;
    assign a_ge_b = (a_ma >= b_ma);
    assign diff = a_ge_b ? (sq_a - sq_b) : (sq_b - sq_a);
    assign quot = diff / `MOCL_MA2_PER_A2;
    assign mag_a2 = (quot[63:32] != 32'h00000000) ? 32'hFFFFFFFF : quot[31:0];

endmodule // mocl_sqdiff
